// >>> rtl/rac_pkg.sv
package rac_pkg;

  // register indices inside the bank (word addresses)
  localparam logic [2:0] IDX_CTRL      = 3'h0;
  localparam logic [2:0] IDX_STATUS    = 3'h1;
  localparam logic [2:0] IDX_CMD       = 3'h2;
  localparam logic [2:0] IDX_CLR_ALIAS = 3'h3;
  localparam logic [2:0] IDX_SET_ALIAS = 3'h4;
  localparam logic [2:0] IDX_DBGCTRL   = 3'h5;

  // implemented (non-reserved) bit masks
  localparam logic [31:0] CTRL_MASK    = 32'h0000_00ff;
  localparam logic [31:0] STATUS_MASK  = 32'h0000_ffff;
  localparam logic [31:0] CMD_MASK     = 32'h0000_000f;
  localparam logic [31:0] SHARED_MASK  = 32'h0000_ffff;
  localparam logic [31:0] DBGCTRL_MASK = 32'h0000_0001;

  // values after reset
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
  localparam logic [31:0] SHARED_RST   = 32'h0000_0000;
  localparam logic [31:0] DBGCTRL_RST  = 32'h0000_0000;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic        set_wr;
    logic [2:0]  addr;
    logic [31:0] wdata;
  } rac_req_t;

endpackage

// >>> rtl/rac_reg_bank.sv
`timescale 1ns/1ns
`default_nettype none
module rac_reg_bank (
  // clock and resets
  input  wire logic             sys_clk_i,
  input  wire logic             rst_i,
  input  wire logic             swrst_i,
  // primary access port
  input  wire rac_pkg::rac_req_t req_i,
  // second write port, clear alias only
  input  wire logic             clr_wr_i,
  input  wire logic [31:0]      clr_wdata_i,
  // read data
  output logic [31:0]           rdata_o,
  // block side
  input  wire logic [31:0]      status_i,
  output logic [31:0]           ctrl_o,
  output logic [31:0]           shared_o,
  output logic [31:0]           cmd_o,
  output logic                  cmd_stb_o,
  output logic [31:0]           dbgctrl_o
);

  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] shared_r;
  logic [31:0] shared_nxt;
  logic [31:0] dbg_r;
  logic [31:0] dbg_nxt;
  logic [31:0] cmd_r;
  logic        cmd_stb_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire wr_ctrl = req_i.wr && req_i.addr == rac_pkg::IDX_CTRL;
  wire wr_cmd  = req_i.wr && req_i.addr == rac_pkg::IDX_CMD;
  wire wr_dbg  = req_i.wr && req_i.addr == rac_pkg::IDX_DBGCTRL;
  wire wr_setp = req_i.wr && req_i.addr == rac_pkg::IDX_SET_ALIAS;
  wire wr_clrp = req_i.wr && req_i.addr == rac_pkg::IDX_CLR_ALIAS;

  // reserved bits are dropped on the way in, so they can never read back
  wire [31:0] wmask_ctrl = req_i.wdata & rac_pkg::CTRL_MASK;
  wire [31:0] set_bits   = (wr_setp || req_i.set_wr) ?
                           (req_i.wdata & rac_pkg::SHARED_MASK) : 32'h0;
  // the clear alias can arrive from the main port or the second port
  wire [31:0] clr_bits   = ((wr_clrp ? req_i.wdata : 32'h0) |
                           (clr_wr_i ? clr_wdata_i : 32'h0)) &
                           rac_pkg::SHARED_MASK;

  // clear applied after set so clear wins; zeros touch nothing
  assign shared_nxt = (shared_r | set_bits) & ~clr_bits;
  assign ctrl_nxt   = wr_ctrl ? wmask_ctrl : ctrl_r;
  assign dbg_nxt    = wr_dbg ? (req_i.wdata & rac_pkg::DBGCTRL_MASK) : dbg_r;

  // only the implemented status bits are visible; the rest read zero
  wire [31:0] status_vis = status_i & rac_pkg::STATUS_MASK;
  wire [31:0] cmd_nxt    = wr_cmd ? (req_i.wdata & rac_pkg::CMD_MASK) :
                           cmd_r;

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rdata_nxt = 32'h0;
    case (req_i.addr)
      rac_pkg::IDX_CTRL:      rdata_nxt = ctrl_r;
      rac_pkg::IDX_STATUS:    rdata_nxt = status_vis;
      rac_pkg::IDX_CMD:       rdata_nxt = 32'h0;
      rac_pkg::IDX_CLR_ALIAS: rdata_nxt = shared_r;
      rac_pkg::IDX_SET_ALIAS: rdata_nxt = shared_r;
      rac_pkg::IDX_DBGCTRL:   rdata_nxt = dbg_r;
      default:                rdata_nxt = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || swrst_i) begin
      ctrl_r   <= rac_pkg::CTRL_RST;
      shared_r <= rac_pkg::SHARED_RST;
    end else begin
      ctrl_r   <= ctrl_nxt;
      shared_r <= shared_nxt;
    end
  end

  // debug control survives the peripheral software reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      dbg_r <= rac_pkg::DBGCTRL_RST;
    end else begin
      dbg_r <= dbg_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || swrst_i) begin
      cmd_r     <= 32'h0;
      cmd_stb_r <= 1'b0;
      rdata_r   <= 32'h0;
    end else begin
      cmd_r     <= cmd_nxt;
      cmd_stb_r <= wr_cmd;
      rdata_r   <= req_i.rd ? rdata_nxt : rdata_r;
    end
  end

  assign rdata_o   = rdata_r;
  assign ctrl_o    = ctrl_r;
  assign shared_o  = shared_r;
  assign cmd_o     = cmd_r;
  assign cmd_stb_o = cmd_stb_r;
  assign dbgctrl_o = dbg_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // every property below lives in the one clock domain; a power reset
  // abandons every attempt in flight but leaves sampled-value history alone
  default clocking chk_cb @(posedge sys_clk_i);
  endclocking

  default disable iff (rst_i);

  // helper terms for the properties below; only quiet_alias is shared by two
  wire quiet_alias = set_bits == 32'h0 && clr_bits == 32'h0;
  wire rd_alias    = req_i.rd &&
                     (req_i.addr == rac_pkg::IDX_SET_ALIAS ||
                      req_i.addr == rac_pkg::IDX_CLR_ALIAS);
  wire rd_status   = req_i.rd && req_i.addr == rac_pkg::IDX_STATUS;
  wire rd_unmapped = req_i.rd && req_i.addr > rac_pkg::IDX_DBGCTRL;
  wire wr_status   = req_i.wr && req_i.addr == rac_pkg::IDX_STATUS;

  // a status write must leave ctrl_r and shared_r untouched; alias traffic in the
  // same cycle is excluded since it may legally move the shared value
  AST_RO_IGNORE: assert property (
    wr_status && !swrst_i && quiet_alias
      |=> ctrl_r == $past(ctrl_r) && shared_r == $past(shared_r))
    else $error("status write disturbed other state");

  // status reads return the live value of the visible bits
  AST_STATUS_READ: assert property (
    rd_status && !swrst_i
      |=> rdata_o == ($past(status_i) & rac_pkg::STATUS_MASK))
    else $error("status read mismatch");

  AST_RW_TAKE: assert property (
    wr_ctrl && !swrst_i
      |=> ctrl_r == ($past(req_i.wdata) & rac_pkg::CTRL_MASK))
    else $error("ctrl write not taken");

  // write-only command lands once and pulses its strobe for one cycle
  AST_CMD_TAKE: assert property (
    wr_cmd && !swrst_i
      |=> cmd_stb_o && cmd_o == ($past(req_i.wdata) & rac_pkg::CMD_MASK))
    else $error("command write not taken");

  AST_CMD_PULSE: assert property (
    !wr_cmd |=> !cmd_stb_o)
    else $error("command strobe without a write");

  AST_RESERVED_ZERO: assert property (
    (ctrl_r & ~rac_pkg::CTRL_MASK) == 32'h0 &&
    (shared_r & ~rac_pkg::SHARED_MASK) == 32'h0 &&
    (dbg_r & ~rac_pkg::DBGCTRL_MASK) == 32'h0)
    else $error("reserved bit set");

  // reads outside the map see nothing
  AST_UNMAPPED_ZERO: assert property (
    rd_unmapped && !swrst_i |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");

  AST_CLR_WINS: assert property (
    (clr_bits & set_bits) != 32'h0
      |=> (shared_r & $past(clr_bits)) == 32'h0)
    else $error("set beat clear");

  AST_SET: assert property (
    set_bits != 32'h0 && !swrst_i
      |=> (shared_r & ($past(set_bits) & ~$past(clr_bits)))
          == ($past(set_bits) & ~$past(clr_bits)))
    else $error("set alias failed");

  AST_ZERO_KEEP: assert property (
    quiet_alias && !swrst_i |=> $stable(shared_r))
    else $error("shared changed without a one written");

  // debug control must ride through the peripheral software reset
  AST_SWRST: assert property (
    swrst_i && !wr_dbg
      |=> ctrl_r == rac_pkg::CTRL_RST &&
          shared_r == rac_pkg::SHARED_RST && dbg_r == $past(dbg_r))
    else $error("software reset wrong");

  AST_ALIAS_READ: assert property (
    rd_alias && !swrst_i |=> rdata_o == $past(shared_r))
    else $error("alias read mismatch");

  AST_CLR: assert property (
    clr_bits != 32'h0 |=> (shared_r & $past(clr_bits)) == 32'h0)
    else $error("clear alias failed");

  // main scenarios worth seeing at least once
  COV_SET: cover property (wr_setp);
  COV_CLR: cover property (wr_clrp);
  COV_BOTH: cover property (req_i.set_wr && clr_wr_i);
  COV_SWRST: cover property (swrst_i && dbg_r != 32'h0);
  COV_CMD: cover property (wr_cmd ##1 cmd_stb_o);

endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic              sys_clk_i   = 1'b0;
  logic              rst_i       = 1'b1;
  logic              swrst_i     = 1'b0;
  rac_pkg::rac_req_t req_i       = '0;
  logic              clr_wr_i    = 1'b0;
  logic [31:0]       clr_wdata_i = 32'h0;
  logic [31:0]       status_i    = 32'h0;
  logic [31:0]       rdata_o, ctrl_o, shared_o, cmd_o, dbgctrl_o;
  logic              cmd_stb_o;
  int                bad_count   = 0;
  int                checks_done = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  rac_reg_bank i_rac_reg_bank (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .swrst_i(swrst_i), .req_i(req_i), .clr_wr_i(clr_wr_i),
    .clr_wdata_i(clr_wdata_i), .rdata_o(rdata_o), .status_i(status_i),
    .ctrl_o(ctrl_o), .shared_o(shared_o), .cmd_o(cmd_o),
    .cmd_stb_o(cmd_stb_o), .dbgctrl_o(dbgctrl_o));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held for exactly one taken edge, outputs read once settled
  task automatic acc(input logic w, input logic s, input logic [2:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_i);
    req_i <= '{wr: w, rd: ~w & ~s, set_wr: s, addr: a, wdata: d};
    @(posedge sys_clk_i);
    req_i <= '0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [31:0] exp);
    acc(1'b0, 1'b0, a, 32'h0);
    chk(rdata_o, exp);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_access;
    acc(1'b1, 1'b0, rac_pkg::IDX_CTRL, 32'hffff_ffff);
    chk(ctrl_o, 32'h0000_00ff);
    acc(1'b1, 1'b0, rac_pkg::IDX_CTRL, 32'h0000_005a);
    rd(rac_pkg::IDX_CTRL, 32'h0000_005a);
    rd(3'h6, 32'h0000_0000);
    @(posedge sys_clk_i) status_i <= 32'h1234_abcd;
    acc(1'b1, 1'b0, rac_pkg::IDX_STATUS, 32'h0000_0000);
    rd(rac_pkg::IDX_STATUS, 32'h0000_abcd);
    acc(1'b1, 1'b0, rac_pkg::IDX_CMD, 32'hffff_fff5);
    chk(cmd_o, 32'h0000_0005);
    chk({31'h0, cmd_stb_o}, 32'h0000_0001);
    @(posedge sys_clk_i) #1;
    chk({31'h0, cmd_stb_o}, 32'h0000_0000);
    rd(rac_pkg::IDX_CMD, 32'h0000_0000);
    $display("test access done");
  endtask
  task automatic t_alias;
    acc(1'b1, 1'b0, rac_pkg::IDX_SET_ALIAS, 32'hffff_00ff);
    chk(shared_o, 32'h0000_00ff);
    acc(1'b1, 1'b0, rac_pkg::IDX_CLR_ALIAS, 32'h0000_000f);
    rd(rac_pkg::IDX_CLR_ALIAS, 32'h0000_00f0);
    rd(rac_pkg::IDX_SET_ALIAS, 32'h0000_00f0);
    acc(1'b1, 1'b0, rac_pkg::IDX_SET_ALIAS, 32'h0000_0000);
    acc(1'b1, 1'b0, rac_pkg::IDX_CLR_ALIAS, 32'h0000_0000);
    chk(shared_o, 32'h0000_00f0);
    // set 0x11 and clear 0x31 together: bits 0 and 4 collide
    @(posedge sys_clk_i);
    req_i <= '{wr: 1'b0, rd: 1'b0, set_wr: 1'b1, addr: 3'h0,
               wdata: 32'h0000_0011};
    clr_wr_i    <= 1'b1;
    clr_wdata_i <= 32'h0000_0031;
    @(posedge sys_clk_i);
    req_i    <= '0;
    clr_wr_i <= 1'b0;
    #1;
    chk(shared_o, 32'h0000_00c0);
    $display("test alias done");
  endtask
  task automatic t_reset;
    acc(1'b1, 1'b0, rac_pkg::IDX_DBGCTRL, 32'hffff_ffff);
    chk(dbgctrl_o, 32'h0000_0001);
    @(posedge sys_clk_i) swrst_i <= 1'b1;
    @(posedge sys_clk_i) swrst_i <= 1'b0;
    #1;
    chk(ctrl_o, rac_pkg::CTRL_RST);
    chk(shared_o, rac_pkg::SHARED_RST);
    chk(dbgctrl_o, 32'h0000_0001);
    @(posedge sys_clk_i) rst_i <= 1'b1;
    @(posedge sys_clk_i) rst_i <= 1'b0;
    #1;
    chk(dbgctrl_o, rac_pkg::DBGCTRL_RST);
    $display("test reset done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_access();
    t_alias();
    t_reset();
    complete_run();
  end
  // about 46 cycles expected; hang limit far beyond that
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
